// ==== rtl/csc_defs.svh ====
`ifndef CSC_DEFS_SVH
`define CSC_DEFS_SVH

// word indices; documented offsets kept as register indices
`define CSC_IDX_TEXT        8'hb2
`define CSC_IDX_SETUP       8'hd0
`define CSC_IDX_TEXT_LEN    8'he0
`define CSC_IDX_CTRL        8'he1
`define CSC_IDX_BUDGET      8'he2
`define CSC_IDX_IRQ_STAT    8'he3
`define CSC_IDX_IRQ_MASK    8'he4
`define CSC_IDX_STATUS      8'he5
`define CSC_TEXT_WORDS      8
`define CSC_TEXT_MAX_BYTES  6'h20
`define CSC_BUDGET_BYTES    8'h80
`define CSC_SETUP_RESET     16'h1902
`define CSC_SETUP_WMASK     16'hff07
`define CSC_BLANK_MSB       15
`define CSC_BLANK_LSB       11
`define CSC_BLANK_MAX       5'h1a
`define CSC_COUNT_MSB       10
`define CSC_COUNT_LSB       8
`define CSC_SLOPE_BIT       2
`define CSC_RANGE_MSB       1
`define CSC_RANGE_LSB       0
`define CSC_RANGE_UNUSED    2'h3
`define CSC_BLANK_STEP_NS   32
`define CSC_CLK_PERIOD_NS   25
// cycles per blanking step, rounded up
`define CSC_BLANK_STEP_CYC  ((`CSC_BLANK_STEP_NS + `CSC_CLK_PERIOD_NS - 1) / `CSC_CLK_PERIOD_NS)
`define CSC_CTRL_COMMIT     0
`define CSC_CTRL_RELOAD     1
`define CSC_CTRL_WRITE      2
`define CSC_IRQ_FAULT       0
`define CSC_IRQ_REFUSED     1
`define CSC_IRQ_BADCODE     2
`endif

// ==== rtl/csc_pkg.sv ====
package csc_pkg;
    typedef enum logic [2:0] {
        CSC_IDLE  = 3'b001,
        CSC_BLANK = 3'b010,
        CSC_SENSE = 3'b100
    } csc_sense_state_t;
endpackage

// ==== rtl/csc_fault_counter.sv ====
`include "csc_defs.svh"
module csc_fault_counter (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       cycle_start,
    input  wire logic       event_seen,
    input  wire logic [2:0] count_code,
    output logic            fault
);
    logic       hit_q, hit_d;
    logic [3:0] run_q, run_d;
    logic       fault_q, fault_d;
    logic [3:0] need;

    assign need = {count_code, 1'b1};
    assign fault = fault_q;

    always_comb begin
        hit_d   = hit_q;
        run_d   = run_q;
        fault_d = fault_q;
        if (event_seen) begin
            hit_d = 1'b1;
        end
        if (cycle_start) begin
            // one event per cycle, eventless cycle clears
            if (hit_q) begin
                run_d = (run_q == 4'hf) ? run_q : run_q + 4'h1;
            end else begin
                run_d = 4'h0;
            end
            hit_d   = 1'b0;
            // compare against need minus one so a saturated run cannot wrap
            fault_d = hit_q && (run_q >= (need - 4'h1));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hit_q   <= 1'b0;
            run_q   <= 4'h0;
            fault_q <= 1'b0;
        end else begin
            hit_q   <= hit_d;
            run_q   <= run_d;
            fault_q <= fault_d;
        end
    end
endmodule

// ==== rtl/csc_regs.sv ====
`include "csc_defs.svh"
module csc_regs (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        switch_cycle_pin,
    input  wire logic        overcurrent_event,
    input  wire logic        undercurrent_event,
    input  wire logic [7:0]  other_slots_used,
    output logic             sense_window,
    output logic             sense_up_slope,
    output logic [1:0]       sense_range,
    output logic             current_fault,
    output logic             irq
);
    localparam int WORDS = `CSC_TEXT_WORDS;

    // text staging, committed image and setup word
    logic [31:0] stage_q [WORDS];
    logic [31:0] stage_d [WORDS];
    logic [31:0] image_q [WORDS];
    logic [31:0] image_d [WORDS];
    logic [5:0]  stage_len_q, stage_len_d;
    logic [5:0]  image_len_q, image_len_d;
    logic [7:0]  pending_q, pending_d;
    logic [15:0] setup_q, setup_d;
    logic [2:0]  istat_q, istat_d;
    logic [2:0]  imask_q, imask_d;
    logic [31:0] rdata_q, rdata_d;
    logic        ready_q, ready_d;
    logic        err_q, err_d;
    logic        irq_q, irq_d;

    logic        wr_en, rd_en;
    logic [7:0]  idx;
    logic        addr_ok;
    logic        in_text;
    logic [2:0]  widx;
    logic [8:0]  used_next;
    logic        fault_w;
    logic        fault_prev_q;
    logic        badcode;

    assign wr_en   = psel && penable && pwrite && !ready_q;
    assign rd_en   = psel && penable && !pwrite && !ready_q;
    // misaligned or out-of-window addresses fall on an unmapped index
    assign addr_ok = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
    assign idx     = addr_ok ? paddr[9:2] : 8'hff;
    assign in_text = (idx >= `CSC_IDX_TEXT) && (idx < `CSC_IDX_TEXT + 8'(WORDS));
    assign widx    = 3'(idx - `CSC_IDX_TEXT);
    assign badcode = (setup_q[`CSC_RANGE_MSB:`CSC_RANGE_LSB] == `CSC_RANGE_UNUSED)
                     || (setup_q[`CSC_BLANK_MSB:`CSC_BLANK_LSB] > `CSC_BLANK_MAX);

    always_comb begin
        stage_d     = stage_q;
        image_d     = image_q;
        stage_len_d = stage_len_q;
        image_len_d = image_len_q;
        pending_d   = pending_q;
        setup_d     = setup_q;
        istat_d     = istat_q;
        imask_d     = imask_q;
        rdata_d     = 32'h0000_0000;
        ready_d     = 1'b0;
        err_d       = 1'b0;
        used_next   = 9'(other_slots_used) + 9'(pending_q) + 9'(pwdata[13:8]) + 9'h001;
        if ((wr_en || rd_en)) begin
            ready_d = 1'b1;
        end
        if (wr_en) begin
            if (in_text) begin
                stage_d[widx] = pwdata;
            end else begin
                unique case (idx)
                    `CSC_IDX_SETUP: begin
                        setup_d = pwdata[15:0] & `CSC_SETUP_WMASK;
                    end
                    `CSC_IDX_TEXT_LEN: begin
                        // a stored length above 32 bytes is refused
                        if (pwdata[5:0] > `CSC_TEXT_MAX_BYTES) begin
                            istat_d[`CSC_IRQ_REFUSED] = 1'b1;
                            err_d = 1'b1;
                        end else begin
                            stage_len_d = pwdata[5:0];
                        end
                    end
                    `CSC_IDX_CTRL: begin
                        if (pwdata[`CSC_CTRL_WRITE]) begin
                            if (pwdata[13:8] > `CSC_TEXT_MAX_BYTES || used_next > 9'(`CSC_BUDGET_BYTES)) begin
                                istat_d[`CSC_IRQ_REFUSED] = 1'b1;
                                err_d = 1'b1;
                            end else begin
                                stage_len_d = pwdata[13:8];
                                pending_d   = 8'(9'(pending_q) + 9'(pwdata[13:8]) + 9'h001);
                            end
                        end
                        if (pwdata[`CSC_CTRL_COMMIT]) begin
                            image_d     = stage_q;
                            image_len_d = stage_len_q;
                        end
                        if (pwdata[`CSC_CTRL_RELOAD]) begin
                            // reload keeps only the committed string in the budget
                            stage_d     = image_q;
                            stage_len_d = image_len_q;
                            pending_d   = (image_len_q == 6'h00) ? 8'h00 : 8'(image_len_q) + 8'h01;
                        end
                    end
                    `CSC_IDX_IRQ_STAT: istat_d = istat_q & ~pwdata[2:0];
                    `CSC_IDX_IRQ_MASK: imask_d = pwdata[2:0];
                    default: err_d = 1'b1;
                endcase
            end
        end
        if (rd_en) begin
            if (in_text) begin
                rdata_d = stage_q[widx];
            end else begin
                unique case (idx)
                    `CSC_IDX_SETUP:    rdata_d = {16'h0000, setup_q};
                    `CSC_IDX_TEXT_LEN: rdata_d = {26'h0, stage_len_q};
                    `CSC_IDX_BUDGET:   rdata_d = {24'h0, pending_q};
                    `CSC_IDX_IRQ_STAT: rdata_d = {29'h0, istat_q};
                    `CSC_IDX_IRQ_MASK: rdata_d = {29'h0, imask_q};
                    `CSC_IDX_STATUS:   rdata_d = {30'h0, badcode, current_fault};
                    `CSC_IDX_CTRL:     rdata_d = 32'h0000_0000;
                    default:           err_d = 1'b1;
                endcase
            end
        end
        // set wins over a same-cycle clear
        if (fault_w && !fault_prev_q) begin
            istat_d[`CSC_IRQ_FAULT] = 1'b1;
        end
        if (badcode) begin
            istat_d[`CSC_IRQ_BADCODE] = 1'b1;
        end
        irq_d = |(istat_d & imask_d);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < WORDS; i++) begin
                stage_q[i] <= 32'h0000_0000;
                image_q[i] <= 32'h0000_0000;
            end
            stage_len_q <= 6'h00;
            image_len_q <= 6'h00;
            pending_q   <= 8'h00;
            setup_q     <= `CSC_SETUP_RESET;
            istat_q     <= 3'h0;
            imask_q     <= 3'h0;
            rdata_q     <= 32'h0000_0000;
            ready_q     <= 1'b0;
            err_q       <= 1'b0;
            irq_q       <= 1'b0;
        end else begin
            stage_q     <= stage_d;
            image_q     <= image_d;
            stage_len_q <= stage_len_d;
            image_len_q <= image_len_d;
            pending_q   <= pending_d;
            setup_q     <= setup_d;
            istat_q     <= istat_d;
            imask_q     <= imask_d;
            rdata_q     <= rdata_d;
            ready_q     <= ready_d;
            err_q       <= err_d;
            irq_q       <= irq_d;
        end
    end

    assign prdata  = rdata_q;
    assign pready  = ready_q;
    assign pslverr = err_q;
    assign irq     = irq_q;

    // pin synchronisers: three stages, a change counts once the last two agree
    logic [2:0] pin_raw;
    logic [2:0] pin_now;
    logic [2:0] pin_last;
    logic       cycle_start, ev_now;
    assign pin_raw = {undercurrent_event, overcurrent_event, switch_cycle_pin};
    for (genvar g = 0; g < 3; g++) begin : g_sync
        logic [2:0] sync_q;
        logic       lvl_q;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                sync_q <= 3'h0;
                lvl_q  <= 1'b0;
            end else begin
                sync_q <= {sync_q[1:0], pin_raw[g]};
                lvl_q  <= pin_now[g];
            end
        end
        // the level holds while stages two and three disagree
        assign pin_now[g]  = (sync_q[1] == sync_q[2]) ? sync_q[2] : lvl_q;
        assign pin_last[g] = lvl_q;
    end
    assign cycle_start = pin_now[0] && !pin_last[0];

    // blanking timer per switching cycle
    csc_pkg::csc_sense_state_t st_q, st_d;
    logic [7:0] blank_q, blank_d;
    logic       win_q;
    always_comb begin
        st_d    = st_q;
        blank_d = blank_q;
        if (cycle_start) begin
            // blanking code times two clocks (32 ns rounded up), the cycle at count zero counts as the last
            if (setup_q[`CSC_BLANK_MSB:`CSC_BLANK_LSB] == 5'h00) begin
                st_d = csc_pkg::CSC_SENSE;
            end else begin
                blank_d = 8'(setup_q[`CSC_BLANK_MSB:`CSC_BLANK_LSB] * `CSC_BLANK_STEP_CYC) - 8'h01;
                st_d    = csc_pkg::CSC_BLANK;
            end
        end else begin
            unique case (st_q)
                csc_pkg::CSC_IDLE: st_d = csc_pkg::CSC_IDLE;
                csc_pkg::CSC_BLANK: begin
                    if (blank_q == 8'h00) begin
                        st_d = csc_pkg::CSC_SENSE;
                    end else begin
                        blank_d = blank_q - 8'h01;
                    end
                end
                csc_pkg::CSC_SENSE: st_d = csc_pkg::CSC_SENSE;
                default: st_d = csc_pkg::CSC_IDLE;
            endcase
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q         <= csc_pkg::CSC_IDLE;
            blank_q      <= 8'h00;
            win_q        <= 1'b0;
            fault_prev_q <= 1'b0;
        end else begin
            st_q         <= st_d;
            blank_q      <= blank_d;
            win_q        <= (st_d == csc_pkg::CSC_SENSE);
            fault_prev_q <= fault_w;
        end
    end
    // events count only outside blanking, with a valid range and blanking code
    assign ev_now = win_q && !badcode && (pin_now[1] || pin_now[2]);

    csc_fault_counter u_count (
        .pclk        (pclk),
        .presetn     (presetn),
        .cycle_start (cycle_start),
        .event_seen  (ev_now),
        .count_code  (setup_q[`CSC_COUNT_MSB:`CSC_COUNT_LSB]),
        .fault       (fault_w)
    );

    assign sense_window   = win_q;
    assign sense_up_slope = setup_q[`CSC_SLOPE_BIT];
    assign sense_range    = setup_q[`CSC_RANGE_MSB:`CSC_RANGE_LSB];
    assign current_fault  = fault_w;
endmodule

// ==== test/csc_stage_model.sv ====
module csc_stage_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       start,
    input  wire logic [7:0] pattern,
    input  wire logic       use_uc,
    output logic            switch_cycle_pin,
    output logic            overcurrent_event,
    output logic            undercurrent_event
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [4:0] ph_q;
    logic [7:0] sh_q;
    logic       ev;
    // one pattern bit per switching cycle of 20 clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_q <= 5'h00;
            sh_q <= 8'h00;
        end else begin
            ph_q <= (ph_q == 5'h13) ? 5'h00 : ph_q + 5'h01;
            sh_q <= start ? pattern : ((ph_q == 5'h13) ? (sh_q >> 1) : sh_q);
        end
    end
    assign switch_cycle_pin = ph_q < 5'h0a;
    assign ev = sh_q[0] && ph_q >= 5'h0c && ph_q < 5'h10;
    assign overcurrent_event = ev && !use_uc;
    assign undercurrent_event = ev && use_uc;
endmodule

// ==== test/csc_regs_chk.sv ====
`include "csc_defs.svh"
module csc_regs_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        overcurrent_event,
    input wire logic        undercurrent_event,
    input wire logic        sense_up_slope,
    input wire logic [1:0]  sense_range,
    input wire logic        current_fault,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [7:0] quiet_q;
    logic [7:0] quiet_d;
    logic       wr_setup;
    logic       ok_code;
    always_comb begin
        quiet_d = (overcurrent_event || undercurrent_event) ? 8'h00 : (&quiet_q ? quiet_q : quiet_q + 8'h01);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quiet_q <= 8'hff;
        end else begin
            quiet_q <= quiet_d;
        end
    end
    assign wr_setup = psel && penable && pready && pwrite && paddr == {2'h0, `CSC_IDX_SETUP, 2'h0};
    assign ok_code = pwdata[1:0] != 2'h3 && pwdata[15:11] <= 5'h1a;
    property p_answer;
        $rose(penable) && psel |-> !pready ##1 pready;
    endproperty
    a_answer: assert property (p_answer) else $error("pready not one cycle into access");
    property p_pulse;
        pready |-> psel && penable ##1 !pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pready outside access or too long");
    property p_slope;
        wr_setup && ok_code |=> sense_up_slope == $past(pwdata[2]);
    endproperty
    a_slope: assert property (p_slope) else $error("slope select not applied");
    property p_range;
        wr_setup && ok_code |=> sense_range == $past(pwdata[1:0]);
    endproperty
    a_range: assert property (p_range) else $error("sense range not applied");
    property p_reset;
        $rose(presetn) |-> sense_range == 2'h2 && !sense_up_slope && !irq && !current_fault;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs wrong after reset");
    property p_long;
        pready && pwrite && paddr == {2'h0, `CSC_IDX_CTRL, 2'h0} && pwdata[2] && pwdata[13:8] > 6'h20 |-> pslverr;
    endproperty
    a_long: assert property (p_long) else $error("long text write accepted");
    property p_unmap;
        pready && paddr[11:10] != 2'h0 |-> pslverr;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
    property p_fault;
        $rose(current_fault) |-> quiet_q < 8'h28;
    endproperty
    a_fault: assert property (p_fault) else $error("fault without recent event");
endmodule
bind csc_regs csc_regs_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .overcurrent_event(overcurrent_event), .undercurrent_event(undercurrent_event),
    .sense_up_slope(sense_up_slope), .sense_range(sense_range), .current_fault(current_fault), .irq(irq));

// ==== test/current_sense_config_regs_test.sv ====
`include "csc_defs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin $display("wrong value %s exp %h got %h", nm, e, g); err_count++; end end
module current_sense_config_regs_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic sw, oc, uc, win, slope, fault, start, use_uc, re;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rq;
    logic [7:0]  other, pattern;
    logic [1:0]  range;
    int          err_count, n_tests, i;
    csc_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .switch_cycle_pin(sw), .overcurrent_event(oc), .undercurrent_event(uc), .other_slots_used(other),
        .sense_window(win), .sense_up_slope(slope), .sense_range(range), .current_fault(fault), .irq(irq));
    csc_stage_model stage (.pclk(pclk), .presetn(presetn), .start(start), .pattern(pattern),
        .use_uc(use_uc), .switch_cycle_pin(sw), .overcurrent_event(oc), .undercurrent_event(uc));
    always #12.5 pclk = ~pclk;
    function automatic logic [11:0] ad(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait for the answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic run_events(input logic [7:0] p, input logic u);
        pattern <= p;
        use_uc <= u;
        start <= 1'b1;
        @(posedge pclk);
        start <= 1'b0;
        repeat (200) @(posedge pclk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata, start, pattern, use_uc} = '0;
        other = 8'd95;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ad(`CSC_IDX_SETUP), 32'h0);
        `CHK("setup", 32'h1902, rq)
        for (i = 0; i < 8; i++) begin
            apb(1'b0, ad(`CSC_IDX_TEXT + i[7:0]), 32'h0);
            `CHK("text", 32'h0, rq)
        end
        apb(1'b0, 12'hffc, 32'h0);
        `CHK("unmapped", 1'b1, re)
        $display("test reset done");
        apb(1'b1, ad(`CSC_IDX_SETUP), 32'hffff);
        apb(1'b0, ad(`CSC_IDX_SETUP), 32'h0);
        `CHK("setup rw", 32'hff07, rq)
        apb(1'b0, ad(`CSC_IDX_STATUS), 32'h0);
        `CHK("bad code", 1'b1, rq[1])
        for (i = 0; i < 3; i++) begin
            apb(1'b1, ad(`CSC_IDX_SETUP), 32'hd700 | ((i & 1) << 2) | i);
            apb(1'b0, ad(`CSC_IDX_SETUP), 32'h0);
            `CHK("setup", 32'hd700 | ((i & 1) << 2) | i, rq)
            `CHK("range", i[1:0], range)
            `CHK("slope", i[0], slope)
        end
        apb(1'b1, ad(`CSC_IDX_IRQ_MASK), 32'h7);
        repeat (2) @(posedge pclk);
        `CHK("irq on", 1'b1, irq)
        apb(1'b1, ad(`CSC_IDX_IRQ_STAT), 32'h7);
        repeat (2) @(posedge pclk);
        `CHK("irq off", 1'b0, irq)
        $display("test setup done");
        for (i = 0; i < 8; i++) apb(1'b1, ad(`CSC_IDX_TEXT + i[7:0]), 32'h41424344 + i);
        apb(1'b1, ad(`CSC_IDX_CTRL), 32'h2004);
        `CHK("full fits", 1'b0, re)
        apb(1'b1, ad(`CSC_IDX_CTRL), 32'h0004);
        `CHK("over budget", 1'b1, re)
        apb(1'b1, ad(`CSC_IDX_CTRL), 32'h2104);
        `CHK("too long", 1'b1, re)
        apb(1'b1, ad(`CSC_IDX_TEXT_LEN), 32'h21);
        `CHK("long length", 1'b1, re)
        apb(1'b0, ad(`CSC_IDX_IRQ_STAT), 32'h0);
        `CHK("refused irq", 1'b1, rq[1])
        apb(1'b1, ad(`CSC_IDX_CTRL), 32'h2);
        apb(1'b0, ad(`CSC_IDX_BUDGET), 32'h0);
        `CHK("budget", 32'h0, rq)
        apb(1'b1, ad(`CSC_IDX_TEXT), 32'h61626364);
        apb(1'b1, ad(`CSC_IDX_CTRL), 32'h0404);
        apb(1'b1, ad(`CSC_IDX_CTRL), 32'h1);
        apb(1'b1, ad(`CSC_IDX_CTRL), 32'h2);
        apb(1'b0, ad(`CSC_IDX_TEXT), 32'h0);
        `CHK("committed", 32'h61626364, rq)
        apb(1'b0, ad(`CSC_IDX_BUDGET), 32'h0);
        `CHK("budget kept", 32'h5, rq)
        $display("test text done");
        apb(1'b1, ad(`CSC_IDX_SETUP), 32'h1902);
        apb(1'b1, ad(`CSC_IDX_IRQ_STAT), 32'h7);
        run_events(8'h6d, 1'b0);
        apb(1'b0, ad(`CSC_IDX_IRQ_STAT), 32'h0);
        `CHK("no fault", 1'b0, rq[0])
        run_events(8'h3f, 1'b1);
        apb(1'b0, ad(`CSC_IDX_IRQ_STAT), 32'h0);
        `CHK("fault", 1'b1, rq[0])
        `CHK("fault irq", 1'b1, irq)
        `CHK("fault cleared", 1'b0, fault)
        // window shuts four clocks after the pin edge, for three blanking steps
        @(posedge sw);
        repeat (5) @(posedge pclk);
        `CHK("blank start", 1'b0, win)
        repeat (3 * `CSC_BLANK_STEP_CYC - 1) @(posedge pclk);
        `CHK("blank end", 1'b0, win)
        @(posedge pclk);
        `CHK("window open", 1'b1, win)
        $display("test fault done");
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        tally_and_finish();
    end
endmodule
